// ---- design/serial_config_pkg.sv ----
// Operation
// - Each block's final power-down is the OR of all requests reaching it.
// - Global pin and full-off bits beat the medium pins and partial bits, then single bits.
// - Partial power-down comes from the amp or converter pins or partial bits.
// - Partial power-down keeps references and LVDS clocks running.
// - Full-off bits or the global pin switch off every block, references included; LVDS output disable follows only its own bit.
// - Registers keep their contents during any power-down.
// - Register 1 bits 9:2 power down channels 1 to 8 individually.
// - Serial data is sampled on rising serial clock while select is low.
// - Every 24th rising edge commits the word; partial excess bits are dropped.
// - Edges are counted in groups of 24 from the select falling edge.
// - A frame is an 8-bit address followed by 16 data bits.
// - Readback: set readback enable, then send a frame with the target address.
// - Readback drives 16 data bits on serial out, changing after falling edges.
// - While readback is enabled only a write to register 0 takes effect.
// - Serial out is released unless readback enable is set.
// - A high pulse on the hardware reset pin restores all defaults.
// - Writing the soft reset bit clears every register, then the bit clears itself.
// - Three-bit test-pattern field selects the output data source.
// - Low-latency bit selects 11-cycle or 8-cycle output latency.
package serial_config_pkg;
    localparam logic [7:0] REG_CTRL_ADDR = 8'h00;
    localparam logic [7:0] REG_POWER_ADDR = 8'h01;
    localparam logic [7:0] REG_PATTERN_ADDR = 8'h02;
    localparam logic [7:0] REG_INVERT_ADDR = 8'h03;
    localparam logic [15:0] REG_RESET_VALUE = 16'h0000;
    localparam int SOFT_RESET_BIT = 0;
    localparam int READBACK_BIT = 1;
    localparam int CONV_FULL_BIT = 0;
    localparam int LVDS_DISABLE_BIT = 1;
    localparam int CHAN_LSB = 2;
    localparam int CONV_PARTIAL_BIT = 10;
    localparam int AMP_PARTIAL_BIT = 0;
    localparam int AMP_FULL_BIT = 1;
    localparam int PREAMP_BIT = 2;
    localparam int ATTEN_BIT = 3;
    localparam int LOW_LATENCY_BIT = 12;
    localparam int PATTERN_LSB = 13;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] ADDR_BITS = 5'h08;
    localparam logic [4:0] LATENCY_NORMAL = 5'h0B;
    localparam logic [4:0] LATENCY_LOW = 5'h08;
    localparam int CLOCK_MHZ = 25;
    localparam int WAKE_CLOCK_US = 50;
    localparam int WAKE_CLOCK_CYCLES = WAKE_CLOCK_US * CLOCK_MHZ;
    typedef enum logic [2:0] {
        PAT_NORMAL, PAT_SYNC, PAT_DESKEW, PAT_CUSTOM, PAT_ONES, PAT_TOGGLE, PAT_ZEROS, PAT_RAMP
    } pattern_type;
endpackage : serial_config_pkg

// ---- design/serial_frame_if.sv ----
`timescale 1ns/10ps
// Frame results from the shifter to the register bank
interface serial_frame_if;
    logic commit;
    logic [7:0] addr;
    logic [15:0] data;
    logic addr_done;
    modport shifter (output commit, output addr, output data, output addr_done);
    modport bank (input commit, input addr, input data, input addr_done);
endinterface : serial_frame_if

// ---- design/serial_shifter.sv ----
`timescale 1ns/10ps
module serial_shifter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clear,
    // Synchronised pins and edges
    input wire logic sel_n,
    input wire logic sel_fall,
    input wire logic sclk_rise,
    input wire logic sdi,
    // Frame output
    serial_frame_if.shifter frame
);
    typedef struct packed {
        logic [4:0] count;
        logic [23:0] shift;
        logic commit;
        logic addr_done;
    } state_type;
    state_type s_q, s_d;
    logic [23:0] next_shift;

    // Shift and count groups of 24
    always_comb begin
        s_d = s_q;
        s_d.commit = 1'b0;
        s_d.addr_done = 1'b0;
        next_shift = {s_q.shift[22:0], sdi}; // MSB first, address first
        if (clear || sel_fall) begin
            s_d.count = 5'h00; // Restart count; a partial group is dropped
        end else if (!sel_n && sclk_rise) begin
            s_d.shift = next_shift; // Sample on rising edge while selected
            if (s_q.count == serial_config_pkg::FRAME_BITS - 5'h01) begin
                s_d.count = 5'h00;
                s_d.commit = 1'b1; // Commit on 24th edge
            end else begin
                s_d.count = s_q.count + 5'h01;
                s_d.addr_done = (s_q.count == serial_config_pkg::ADDR_BITS - 5'h01);
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign frame.commit = s_q.commit;
    assign frame.addr_done = s_q.addr_done;
    assign frame.addr = s_q.commit ? s_q.shift[23:16] : s_q.shift[7:0];
    assign frame.data = s_q.shift[15:0];

    frame_len_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_q.commit |-> $past(s_q.count) == 5'h17) else $error("commit off 24th edge");
    abort_clr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        sel_fall && !clear |=> s_q.count == 5'h00 && !s_q.commit)
        else $error("count not restarted");
    idle_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        sel_n && !sel_fall && !clear |=> $stable(s_q.shift)) else $error("shift while idle");
    frame_cov: cover property (@(posedge core_clk) disable iff (!rst_b) s_q.commit);
endmodule : serial_shifter

// ---- design/serial_config_port.sv ----
`timescale 1ns/10ps
module serial_config_port (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Hardware reset pin, active high
    input wire logic hw_reset_pin,
    // Serial port pins
    input wire logic serial_select_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // Power-down pins
    input wire logic global_powerdown_pin,
    input wire logic amp_chain_powerdown_pin,
    input wire logic converter_powerdown_pin,
    // Final power-down controls
    output logic preamp_pd,
    output logic atten_gain_pd,
    output logic [7:0] converter_channel_pd,
    output logic reference_pd,
    output logic lvds_clock_pd,
    output logic lvds_out_disable,
    // Output data configuration
    output serial_config_pkg::pattern_type pattern_sel,
    output logic [4:0] output_latency,
    output logic digital_bypass,
    output logic [7:0] channel_invert,
    output logic offset_sub_en
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic sclk_d;
        logic sel_d;
    } sync_type;
    sync_type y_q, y_d;
    logic [6:0] pins;
    logic hw_rst, sel_n, sclk, sdi, gpd, apd, cpd;
    logic sclk_rise, sclk_fall, sel_fall;

    assign pins = {hw_reset_pin, serial_select_n, serial_clk, serial_in,
                   global_powerdown_pin, amp_chain_powerdown_pin, converter_powerdown_pin};
    assign {hw_rst, sel_n, sclk, sdi, gpd, apd, cpd} = y_q.s2;

    // Two-stage capture then edge history
    always_comb begin
        y_d = y_q;
        y_d.s1 = pins;
        y_d.s2 = y_q.s1;
        y_d.sclk_d = sclk;
        y_d.sel_d = sel_n;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            y_q <= {7'h20, 7'h20, 1'b0, 1'b1}; // Idle pin levels: select high, rest low
        end else begin
            y_q <= y_d;
        end
    end

    assign sclk_rise = sclk && !y_q.sclk_d;
    assign sclk_fall = !sclk && y_q.sclk_d;
    assign sel_fall = !sel_n && y_q.sel_d;

    // ----------------------------------------------------------------
    // Frame shifter
    // ----------------------------------------------------------------
    serial_frame_if frame ();

    serial_shifter u_shift (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clear(hw_rst),
        .sel_n(sel_n),
        .sel_fall(sel_fall),
        .sclk_rise(sclk_rise),
        .sdi(sdi),
        .frame(frame.shifter)
    );

    // ----------------------------------------------------------------
    // Register bank and readback
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] power;
        logic [15:0] pattern;
        logic [15:0] invert;
        logic [15:0] rd_shift;
        logic out_bit;
        logic loading;
    } bank_type;
    bank_type b_q, b_d;
    logic readback;
    logic [15:0] rd_word;

    assign readback = b_q.ctrl[serial_config_pkg::READBACK_BIT];

    // Readback word for the address just shifted in
    always_comb begin
        case (frame.addr)
            serial_config_pkg::REG_CTRL_ADDR: rd_word = b_q.ctrl;
            serial_config_pkg::REG_POWER_ADDR: rd_word = b_q.power;
            serial_config_pkg::REG_PATTERN_ADDR: rd_word = b_q.pattern;
            serial_config_pkg::REG_INVERT_ADDR: rd_word = b_q.invert;
            default: rd_word = 16'h0000;
        endcase
    end

    // Register writes, resets and readback shifting
    always_comb begin
        b_d = b_q;
        if (hw_rst) begin
            b_d = '0; // Hardware reset pin restores defaults
            b_d.out_bit = b_q.out_bit;
        end else begin
            if (frame.addr_done && readback) begin
                b_d.rd_shift = rd_word; // Load after address byte
                b_d.loading = 1'b1;
            end
            if (sclk_fall && b_q.loading) begin
                b_d.out_bit = b_q.rd_shift[15]; // Change after falling edge
                b_d.rd_shift = {b_q.rd_shift[14:0], 1'b0};
            end
            if (sel_n || frame.commit) begin
                b_d.loading = 1'b0;
            end
            if (frame.commit) begin
                // Only register 0 is writable during readback
                if (frame.addr == serial_config_pkg::REG_CTRL_ADDR) begin
                    b_d.ctrl = frame.data & 16'h0003;
                    if (frame.data[serial_config_pkg::SOFT_RESET_BIT]) begin
                        // Soft reset clears all, bit self-clears
                        b_d.ctrl = serial_config_pkg::REG_RESET_VALUE;
                        b_d.power = serial_config_pkg::REG_RESET_VALUE;
                        b_d.pattern = serial_config_pkg::REG_RESET_VALUE;
                        b_d.invert = serial_config_pkg::REG_RESET_VALUE;
                    end
                end else if (!readback) begin
                    case (frame.addr)
                        serial_config_pkg::REG_POWER_ADDR: b_d.power = frame.data;
                        serial_config_pkg::REG_PATTERN_ADDR: b_d.pattern = frame.data;
                        serial_config_pkg::REG_INVERT_ADDR: b_d.invert = frame.data;
                        default: b_d.power = b_q.power;
                    endcase
                end
            end
        end
    end

    // Bank register; power pins never touch it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

    // Serial out enabled only in readback
    assign serial_out = b_q.out_bit;
    assign serial_out_oe = readback;

    // ----------------------------------------------------------------
    // Power-down combining
    // ----------------------------------------------------------------
    logic amp_full, conv_full, amp_part, conv_part, all_off, amp_off, conv_off;
    logic [7:0] chan_bits;

    assign amp_full = b_q.invert[serial_config_pkg::AMP_FULL_BIT];
    assign conv_full = b_q.power[serial_config_pkg::CONV_FULL_BIT];
    assign amp_part = b_q.invert[serial_config_pkg::AMP_PARTIAL_BIT];
    assign conv_part = b_q.power[serial_config_pkg::CONV_PARTIAL_BIT];
    assign chan_bits = b_q.power[serial_config_pkg::CHAN_LSB +: 8];

    // OR of sources; higher sources cover lower ones
    assign all_off = gpd || amp_full || conv_full; // Full power-down
    assign amp_off = all_off || apd || amp_part; // Partial from pin or bit
    assign conv_off = all_off || cpd || conv_part;
    assign preamp_pd = amp_off || b_q.invert[serial_config_pkg::PREAMP_BIT];
    assign atten_gain_pd = amp_off || b_q.invert[serial_config_pkg::ATTEN_BIT];
    assign reference_pd = all_off; // Partial keeps references
    assign lvds_clock_pd = all_off; // Partial keeps LVDS clocks
    assign lvds_out_disable = b_q.power[serial_config_pkg::LVDS_DISABLE_BIT];

    // Per-channel converter gating
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_chan
            assign converter_channel_pd[ch] = conv_off || chan_bits[ch];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Output configuration
    // ----------------------------------------------------------------
    assign pattern_sel = serial_config_pkg::pattern_type'(
        b_q.pattern[serial_config_pkg::PATTERN_LSB +: 3]);
    assign digital_bypass = b_q.pattern[serial_config_pkg::LOW_LATENCY_BIT];
    assign output_latency = digital_bypass ? serial_config_pkg::LATENCY_LOW
                                           : serial_config_pkg::LATENCY_NORMAL;
    assign channel_invert = b_q.invert[7:0];
    assign offset_sub_en = b_q.invert[8];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    global_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        gpd |-> reference_pd && preamp_pd && atten_gain_pd && &converter_channel_pd)
        else $error("global off incomplete");
    partial_ref_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (apd || cpd) && !all_off |-> !reference_pd && !lvds_clock_pd)
        else $error("partial stopped references");
    chan_map_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        converter_channel_pd[7] == (conv_off || b_q.power[9]))
        else $error("channel 8 mapping");
    oe_rb_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        serial_out_oe == b_q.ctrl[1]) else $error("serial out enable");
    rb_block_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        readback && frame.commit && frame.addr == 8'h02 && !hw_rst |=> $stable(b_q.pattern))
        else $error("write during readback");
    soft_rst_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        frame.commit && frame.addr == 8'h00 && frame.data[0] && !hw_rst
        |=> b_q.ctrl == 16'h0000 && b_q.power == 16'h0000) else $error("soft reset");
    hw_rst_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        hw_rst |=> b_q.pattern == 16'h0000 && b_q.invert == 16'h0000)
        else $error("hardware reset");
    pd_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(gpd) && !frame.commit && !hw_rst |=> $stable(b_q.power))
        else $error("power-down lost state");
    latency_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        output_latency == (b_q.pattern[12] ? 5'h08 : 5'h0B)) else $error("latency");
    rb_cov: cover property (@(posedge core_clk) disable iff (!rst_b) readback && sclk_fall);
    pd_cov: cover property (@(posedge core_clk) disable iff (!rst_b) apd && !all_off);
    sr_cov: cover property (@(posedge core_clk) disable iff (!rst_b) frame.commit && frame.data[0]);
endmodule : serial_config_port

// ---- testbench/serial_master_model.sv ----
`timescale 1ns/10ps
module serial_master_model (
    // Clock
    input wire logic core_clk,
    // Serial pins
    output logic serial_select_n,
    output logic serial_clk,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    // Readback result
    output logic rd_done,
    output logic [15:0] rd_word
);
    // ----------------------------------------
    // Idle levels: select high, clock parked low, data pulled low
    // ----------------------------------------
    initial begin
        serial_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
        rd_done = 1'b0;
        rd_word = 16'h0000;
    end

    // Sends bits[n-1:0] MSB first in one select-low period, 8 core clocks per bit
    task automatic xfer(input logic [79:0] bits, input int n, input bit rd);
        logic [15:0] got;
        got = 16'h0000;
        @(posedge core_clk);
        serial_select_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= bits[i];
            repeat (4) @(posedge core_clk);
            serial_clk <= 1'b1;
            repeat (4) @(posedge core_clk);
            // Sample at the end of the high phase, just before the fall
            if (rd && serial_out_oe && i < 16) begin
                got = {got[14:0], serial_out};
            end
            serial_clk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        serial_select_n <= 1'b1;
        serial_in <= 1'b0;
        if (rd) begin
            rd_word <= got;
            rd_done <= 1'b1;
            @(posedge core_clk);
            rd_done <= 1'b0;
        end
        repeat (8) @(posedge core_clk);
    endtask : xfer
endmodule : serial_master_model

// ---- testbench/test_serial_config_port.sv ----
`timescale 1ns/10ps
module test_serial_config_port;
    logic core_clk;
    logic rst_b;
    logic hw_reset_pin;
    logic gp;
    logic ap;
    logic cp;
    logic sel_n;
    logic sclk;
    logic sdi;
    logic serial_out;
    logic serial_out_oe;
    logic preamp_pd;
    logic atten_gain_pd;
    logic [7:0] converter_channel_pd;
    logic reference_pd;
    logic lvds_clock_pd;
    logic lvds_out_disable;
    serial_config_pkg::pattern_type pattern_sel;
    logic [4:0] output_latency;
    logic digital_bypass;
    logic [7:0] channel_invert;
    logic offset_sub_en;
    logic rd_done;
    logic [15:0] rd_word;
    logic [15:0] exp_reg [4];
    logic [15:0] exp_q [$];
    int seed = 74489;
    int bad_count = 0;
    int checks = 0;

    // Clock generation
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    serial_config_port dut (.core_clk(core_clk), .rst_b(rst_b), .hw_reset_pin(hw_reset_pin),
        .serial_select_n(sel_n), .serial_clk(sclk), .serial_in(sdi),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .global_powerdown_pin(gp), .amp_chain_powerdown_pin(ap),
        .converter_powerdown_pin(cp), .preamp_pd(preamp_pd), .atten_gain_pd(atten_gain_pd),
        .converter_channel_pd(converter_channel_pd), .reference_pd(reference_pd),
        .lvds_clock_pd(lvds_clock_pd), .lvds_out_disable(lvds_out_disable),
        .pattern_sel(pattern_sel), .output_latency(output_latency),
        .digital_bypass(digital_bypass), .channel_invert(channel_invert),
        .offset_sub_en(offset_sub_en));

    serial_master_model model (.core_clk(core_clk), .serial_select_n(sel_n),
        .serial_clk(sclk), .serial_in(sdi), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .rd_done(rd_done), .rd_word(rd_word));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Readback monitor takes the oldest note for each finished read
    always @(posedge core_clk) begin
        if (rd_done === 1'b1) begin
            check("readback", rd_word, exp_q.pop_front());
        end
    end

    // Watchdog
    initial begin
        #3000000;
        bad_count++;
        report_and_stop();
    end

    // Register model update after a committed frame
    task automatic upd(input logic [7:0] a, input logic [15:0] d);
        if (a == 8'h00 && d[0]) begin
            foreach (exp_reg[i]) exp_reg[i] = 16'h0000;
        end else if (a == 8'h00) begin
            exp_reg[0] = d & 16'h0002;
        end else if (a < 8'h04 && !exp_reg[0][1]) begin
            exp_reg[a[1:0]] = d;
        end
    endtask : upd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        model.xfer({56'h0, a, d}, 24, 1'b0);
        upd(a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [15:0] d;
        d = (a == 8'h00) ? 16'h0002 : 16'($random(seed));
        exp_q.push_back((a < 8'h04) ? exp_reg[a[1:0]] : 16'h0000);
        model.xfer({56'h0, a, d}, 24, 1'b1);
        upd(a, d);
    endtask : rd

    task automatic check_outputs();
        logic [15:0] r1;
        logic [15:0] r2;
        logic [15:0] r3;
        logic cv;
        logic am;
        r1 = exp_reg[1];
        r2 = exp_reg[2];
        r3 = exp_reg[3];
        cv = gp | cp | r1[0] | r3[1] | r1[10];
        am = gp | ap | r1[0] | r3[0] | r3[1];
        check("channel_pd", {8'h00, converter_channel_pd}, {8'h00, r1[9:2] | {8{cv}}});
        check("ref_pd", {15'h0, reference_pd}, {15'h0, gp | r1[0] | r3[1]});
        check("lvds_clk_pd", {15'h0, lvds_clock_pd}, {15'h0, gp | r1[0] | r3[1]});
        check("preamp_pd", {15'h0, preamp_pd}, {15'h0, am | r3[2]});
        check("atten_pd", {15'h0, atten_gain_pd}, {15'h0, am | r3[3]});
        check("lvds_dis", {15'h0, lvds_out_disable}, {15'h0, r1[1]});
        check("pattern", {13'h0, pattern_sel}, {13'h0, r2[15:13]});
        check("latency", {11'h0, output_latency}, r2[12] ? 16'h0008 : 16'h000B);
        check("bypass", {15'h0, digital_bypass}, {15'h0, r2[12]});
        check("invert", {8'h00, channel_invert}, {8'h00, r3[7:0]});
        check("offset", {15'h0, offset_sub_en}, {15'h0, r3[8]});
    endtask : check_outputs

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] r1;
        logic [15:0] r2;
        logic [15:0] r3;
        rst_b = 1'b0;
        hw_reset_pin = 1'b0;
        gp = 1'b0;
        ap = 1'b0;
        cp = 1'b0;
        foreach (exp_reg[i]) exp_reg[i] = 16'h0000;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("oe_idle", {15'h0, serial_out_oe}, 16'h0000);
        check_outputs();
        // Every pattern code, three frames per select, odd rounds with excess bits
        for (int i = 0; i < 8; i++) begin
            r1 = 16'($random(seed)) & 16'hEFFF;
            r2 = {i[2:0], 13'($random(seed))} & 16'hFFF8;
            r3 = 16'($random(seed)) & 16'h01FF;
            @(posedge core_clk);
            {gp, ap, cp} <= 3'($random(seed));
            model.xfer({8'h01, r1, 8'h02, r2, 8'h03, r3, 8'h00} >> ((i % 2) ? 3 : 8),
                (i % 2) ? 77 : 72, 1'b0);
            upd(8'h01, r1);
            upd(8'h02, r2);
            upd(8'h03, r3);
            check_outputs();
        end
        // Readback while powered down, refused writes, unmapped address
        wr(8'h00, 16'h0002);
        check("oe_on", {15'h0, serial_out_oe}, 16'h0001);
        for (int a = 0; a < 5; a++) rd(8'(a));
        rd(8'h01);
        wr(8'h00, 16'h0000);
        check("oe_off", {15'h0, serial_out_oe}, 16'h0000);
        // Select rises after ten bits: nothing written
        model.xfer({56'h0, 8'h02, 16'hE000} >> 14, 10, 1'b0);
        check_outputs();
        // Soft reset together with readback enable
        wr(8'h00, 16'h0003);
        check_outputs();
        check("oe_sr", {15'h0, serial_out_oe}, 16'h0000);
        // Hardware reset pin
        wr(8'h02, 16'hA000);
        wr(8'h03, 16'h01FF);
        hw_reset_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        hw_reset_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        foreach (exp_reg[i]) exp_reg[i] = 16'h0000;
        check_outputs();
        // Pins released: sampling clock kept running before normal use resumes
        {gp, ap, cp} <= 3'h0;
        repeat (serial_config_pkg::WAKE_CLOCK_CYCLES) @(posedge core_clk);
        check_outputs();
        report_and_stop();
    end
endmodule : test_serial_config_port
